// ---- ppe_consts.vh ----
// register selects, field positions, reset values and timing for ppe_port
`ifndef PPE_CONSTS_VH
`define PPE_CONSTS_VH
// register select codes on the host port
`define PPE_SEL_DATA 4'h0
`define PPE_SEL_DSR 4'h1
`define PPE_SEL_DCR 4'h2
`define PPE_SEL_EPPA 4'h3
`define PPE_SEL_EPPD 4'h4
`define PPE_SEL_AFIFO 4'h5
`define PPE_SEL_COMPAT_FIFO_PORT 4'h6
`define PPE_SEL_DFIFO 4'h7
`define PPE_SEL_TEST_FIFO_PORT 4'h8
`define PPE_SEL_PORT_CONFIG_A 4'h9
`define PPE_SEL_PORT_CONFIG_B 4'ha
`define PPE_SEL_ECR 4'hb
// line_control fields
`define PPE_DCR_DIR 5
`define PPE_DCR_NINIT 2
`define PPE_DCR_RST 8'h00
// line_status fields
`define PPE_DSR_TMO 0
// extended_control fields and modes
`define PPE_ECR_RST 6'h00
`define PPE_MODE_EPP 3'h4
// port_config_a constant content
`define PPE_PORT_CONFIG_A_VAL 8'h10
// shared fifo geometry
`define PPE_FIFO_DEPTH 16
`define PPE_FIFO_AW 4
// watchdog: 10 us at 40 ns per cycle, rounded down
`define PPE_WD_TIME_NS 10000
`define PPE_CLK_NS 40
`define PPE_WD_CYC (`PPE_WD_TIME_NS / `PPE_CLK_NS)
`endif

// ---- ppe_port.v ----
// parallel port: epp 1.7 cycle engine and ecp register map
`timescale 1ns/1ps
`include "ppe_consts.vh"
// Operation
// - host write to epp register puts address or data byte on bus
// - after the byte is placed, assert data or address strobe
// - write cycle stretched while peripheral holds wait low, until timeout
// - write ends with final sync, strobe release and data latch update
// - read asserts strobe with own drivers off and direction set
// - read cycle stretched while wait is low, until timeout
// - read ends with final sync returning the byte, strobe released
// - after a cycle ends, write flag, direction and data may change
// - write flag low during writes, high otherwise; the code also holds it low while the direction bit is clear
// - peripheral interrupt is active high, passed through uninverted
// - active low reset output returns the peripheral to initial mode
// - only the write flag may be overridden by the control register
// - every ecp port word is eight bits wide
// - all fifo ports share one sixteen byte fifo
// - status and control registers reachable in every mode
// - config b reports selected irq and dma channel, read only
// - watchdog aborts cycles over 10 us, flags status bit 0
module ppe_port (
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // host register port
  input wire io_rd_i,
  input wire io_wr_i,
  input wire [3:0] io_sel_i,
  input wire [7:0] io_wdata_i,
  output wire [7:0] io_rdata_o,
  output wire io_ready_o,
  // parallel data bus
  input wire [7:0] port_data_bus_i,
  output wire [7:0] port_data_out_o,
  output wire port_data_oe_n_o,
  // epp handshake
  output wire host_to_periph_flag_n_o,
  output wire data_phase_strobe_n_o,
  output wire addr_phase_strobe_n_o,
  input wire periph_hold_n_i,
  // status, interrupt and reset pins
  input wire [4:0] periph_status_i,
  input wire periph_irq_line_i,
  output wire periph_irq_o,
  output wire periph_reset_n_o,
  // chip level configuration
  input wire [2:0] cfg_irq_sel_i,
  input wire [2:0] cfg_dma_sel_i
);

  // sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_DRIVE = 2'd1;
  localparam ST_STRB = 2'd2;
  localparam ST_END = 2'd3;
  // integer counts cut to the width of the registers they meet
  localparam integer WD_LIM_N = `PPE_WD_CYC;
  localparam integer FIFO_FULL_N = `PPE_FIFO_DEPTH;
  localparam [8:0] WD_LIM = WD_LIM_N[8:0];
  localparam [4:0] FIFO_FULL = FIFO_FULL_N[4:0];

  // pin synchronisers
  reg [7:0] pd_m_q;
  reg [7:0] pd_s_q;
  reg hold_m_q;
  reg hold_s_q;
  reg [4:0] stat_m_q;
  reg [4:0] stat_s_q;
  reg irq_m_q;
  reg irq_s_q;

  // control state
  reg [1:0] state_q;
  reg cyc_wr_q;
  reg cyc_addr_q;
  reg [7:0] cyc_data_q;
  reg [7:0] rx_q;
  reg [8:0] wd_q;
  reg tmo_q;
  reg [7:0] data_q;
  reg [7:0] dcr_q;
  reg [5:0] ecr_q;

  // shared fifo
  reg [7:0] fifo_mem [0:`PPE_FIFO_DEPTH-1];
  reg [`PPE_FIFO_AW-1:0] wp_q;
  reg [`PPE_FIFO_AW-1:0] rp_q;
  reg [4:0] cnt_q;

  // registered outputs
  reg [7:0] rdata_q;
  reg ready_q;
  reg [7:0] pd_out_q;
  reg pd_oe_n_q;
  reg wflag_n_q;
  reg dstb_n_q;
  reg astb_n_q;
  reg irq_q;
  reg prst_n_q;

  // decoded helpers
  wire req = io_rd_i | io_wr_i;
  wire busy = (state_q != ST_IDLE);
  wire dir_bit = dcr_q[`PPE_DCR_DIR];
  wire epp_mode = (ecr_q[5:3] == `PPE_MODE_EPP);
  // the pointers alone cannot tell full from empty, the count can
  wire fifo_full = (cnt_q == FIFO_FULL);
  wire fifo_empty = (cnt_q == 5'd0);
  wire sel_epp = (io_sel_i == `PPE_SEL_EPPA) |
                 (io_sel_i == `PPE_SEL_EPPD);
  wire sel_push = (io_sel_i == `PPE_SEL_AFIFO) |
                  (io_sel_i == `PPE_SEL_COMPAT_FIFO_PORT) |
                  (io_sel_i == `PPE_SEL_DFIFO) |
                  (io_sel_i == `PPE_SEL_TEST_FIFO_PORT);
  wire sel_pop = (io_sel_i == `PPE_SEL_DFIFO) |
                 (io_sel_i == `PPE_SEL_TEST_FIFO_PORT);
  // epp cycles start only from idle and only in epp mode
  wire start_epp = (state_q == ST_IDLE) & req & sel_epp & epp_mode;
  wire simple = (state_q == ST_IDLE) & req & ~(sel_epp & epp_mode);
  wire push = simple & io_wr_i & sel_push & ~fifo_full;
  wire pop = simple & io_rd_i & sel_pop & ~fifo_empty;
  // watchdog runs from the drive state, so it spans the whole cycle
  wire wd_over = (wd_q >= WD_LIM);

  reg [7:0] rd_mux;

  // read data for registers answered without an epp cycle
  always @* begin
    rd_mux = 8'h00;
    case (io_sel_i)
      `PPE_SEL_DATA: rd_mux = dir_bit ? pd_s_q : data_q;
      `PPE_SEL_DSR: rd_mux = {~stat_s_q[4], stat_s_q[3:0],
                              2'b00, tmo_q};
      `PPE_SEL_DCR: rd_mux = {2'b00, dcr_q[5:0]};
      `PPE_SEL_DFIFO: rd_mux = fifo_mem[rp_q];
      `PPE_SEL_TEST_FIFO_PORT: rd_mux = fifo_mem[rp_q];
      `PPE_SEL_PORT_CONFIG_A: rd_mux = `PPE_PORT_CONFIG_A_VAL;
      `PPE_SEL_PORT_CONFIG_B: rd_mux = {1'b0, irq_s_q, cfg_irq_sel_i,
                                cfg_dma_sel_i};
      `PPE_SEL_ECR: rd_mux = {ecr_q, fifo_full, fifo_empty};
      default: rd_mux = 8'h00;
    endcase
  end

  // two flip-flop synchronisers for every pin input
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_m_q <= 8'h00;
      pd_s_q <= 8'h00;
      hold_m_q <= 1'b1;
      hold_s_q <= 1'b1;
      stat_m_q <= 5'h00;
      stat_s_q <= 5'h00;
      irq_m_q <= 1'b0;
      irq_s_q <= 1'b0;
    end else begin
      pd_m_q <= port_data_bus_i;
      pd_s_q <= pd_m_q;
      hold_m_q <= periph_hold_n_i;
      hold_s_q <= hold_m_q;
      stat_m_q <= periph_status_i;
      stat_s_q <= stat_m_q;
      irq_m_q <= periph_irq_line_i;
      irq_s_q <= irq_m_q;
    end
  end

  // epp cycle sequencer, watchdog and register writes
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cyc_wr_q <= 1'b0;
      cyc_addr_q <= 1'b0;
      cyc_data_q <= 8'h00;
      rx_q <= 8'h00;
      wd_q <= 9'h000;
      tmo_q <= 1'b0;
      data_q <= 8'h00;
      dcr_q <= `PPE_DCR_RST;
      ecr_q <= `PPE_ECR_RST;
      rdata_q <= 8'h00;
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          wd_q <= 9'h000;
          if (start_epp) begin
            cyc_wr_q <= io_wr_i;
            cyc_addr_q <= (io_sel_i == `PPE_SEL_EPPA);
            cyc_data_q <= io_wdata_i;
            state_q <= ST_DRIVE;
          end else if (simple) begin
            ready_q <= 1'b1;
            rdata_q <= io_rd_i ? rd_mux : 8'h00;
            if (io_rd_i && io_sel_i == `PPE_SEL_DSR)
              tmo_q <= 1'b0; // status read clears the timeout
            if (io_wr_i) begin
              case (io_sel_i)
                `PPE_SEL_DATA: data_q <= io_wdata_i;
                `PPE_SEL_DCR: dcr_q <= io_wdata_i;
                `PPE_SEL_ECR: ecr_q <= io_wdata_i[7:2];
                default: data_q <= data_q;
              endcase
            end
          end
        end
        ST_DRIVE: begin
          // byte sits on the bus one cycle ahead of the strobe
          wd_q <= wd_q + 9'd1;
          state_q <= ST_STRB;
        end
        ST_STRB: begin
          wd_q <= wd_q + 9'd1;
          if (hold_s_q) begin
            rx_q <= pd_s_q;
            state_q <= ST_END;
          end else if (wd_over) begin
            tmo_q <= 1'b1;
            state_q <= ST_END;
          end else begin
            state_q <= ST_STRB;
          end
        end
        ST_END: begin
          // an aborted read hands back the last captured byte
          ready_q <= 1'b1;
          rdata_q <= cyc_wr_q ? 8'h00 : rx_q;
          if (cyc_wr_q)
            data_q <= cyc_data_q;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // shared sixteen byte fifo behind all fifo ports
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_q <= {`PPE_FIFO_AW{1'b0}};
      rp_q <= {`PPE_FIFO_AW{1'b0}};
      cnt_q <= 5'd0;
    end else begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 5'd1;
      else if (pop && !push)
        cnt_q <= cnt_q - 5'd1;
    end
  end

  // fifo storage, no reset needed
  always @(posedge clk_sys_i) begin
    if (push)
      fifo_mem[wp_q] <= io_wdata_i;
  end

  // pin drivers, registered from the sequencer state
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_out_q <= 8'h00;
      pd_oe_n_q <= 1'b1;
      wflag_n_q <= 1'b1;
      dstb_n_q <= 1'b1;
      astb_n_q <= 1'b1;
      irq_q <= 1'b0;
      prst_n_q <= 1'b0;
    end else begin
      // write cycles drive the latched byte, reads release the bus
      pd_out_q <= (busy & cyc_wr_q) ? cyc_data_q : data_q;
      pd_oe_n_q <= busy ? ~cyc_wr_q : dir_bit;
      // direction bit low forces the flag low even in a read
      wflag_n_q <= dir_bit & ~(busy & cyc_wr_q);
      dstb_n_q <= ~((state_q == ST_STRB) & ~cyc_addr_q);
      astb_n_q <= ~((state_q == ST_STRB) & cyc_addr_q);
      irq_q <= irq_s_q;
      prst_n_q <= dcr_q[`PPE_DCR_NINIT];
    end
  end

  // outputs straight from flip-flops
  assign io_rdata_o = rdata_q;
  assign io_ready_o = ready_q;
  assign port_data_out_o = pd_out_q;
  assign port_data_oe_n_o = pd_oe_n_q;
  assign host_to_periph_flag_n_o = wflag_n_q;
  assign data_phase_strobe_n_o = dstb_n_q;
  assign addr_phase_strobe_n_o = astb_n_q;
  assign periph_irq_o = irq_q;
  assign periph_reset_n_o = prst_n_q;

endmodule

// ---- ppe_port_sva.sv ----
// assertions on the epp pins of ppe_port
`timescale 1ns/1ps
`include "ppe_consts.vh"
module ppe_port_sva (
  // clock, reset, host request and cable pins
  input wire clk_sys_i,
  input wire nrst_i,
  input wire io_wr_i,
  input wire [3:0] io_sel_i,
  input wire io_ready_o,
  input wire port_data_oe_n_o,
  input wire [7:0] port_data_out_o,
  input wire host_to_periph_flag_n_o,
  input wire data_phase_strobe_n_o,
  input wire addr_phase_strobe_n_o,
  input wire periph_hold_n_i,
  input wire periph_irq_line_i,
  input wire periph_irq_o
);
  wire stb_n = data_phase_strobe_n_o & addr_phase_strobe_n_o;
  reg [8:0] low_q;
  // cycles the current strobe has stayed low
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) low_q <= 9'h000;
    else low_q <= stb_n ? 9'h000 : low_q + 9'h001;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // strobe released at the end of a cycle
  sequence stb_end;
    $rose(stb_n);
  endsequence
  chk_one_strobe: assert property (
    data_phase_strobe_n_o || addr_phase_strobe_n_o) else $error("strobes");
  chk_end_sync: assert property (
    stb_end |-> io_ready_o) else $error("no sync");
  chk_write_drive: assert property (
    !stb_n && !host_to_periph_flag_n_o |->
    !port_data_oe_n_o && $stable(port_data_out_o)) else $error("wr bus");
  chk_read_float: assert property (
    !stb_n && host_to_periph_flag_n_o |-> port_data_oe_n_o)
    else $error("rd bus");
  chk_wait_holds: assert property (
    (stb_end ##0 low_q < 9'd200) |-> $past(periph_hold_n_i, 2) ||
    $past(periph_hold_n_i, 3) || $past(periph_hold_n_i, 4))
    else $error("wait");
  chk_watchdog_cap: assert property (
    low_q <= 9'd260) else $error("watchdog");
  chk_irq_pass: assert property (
    periph_irq_o == $past(periph_irq_line_i, 3)) else $error("irq");
  chk_quick_answer: assert property (
    io_wr_i && io_sel_i == `PPE_SEL_DCR |=> io_ready_o) else $error("dcr");
endmodule
bind ppe_port ppe_port_sva chk_u (.*);

// ---- ppe_periph_model.sv ----
// cable-side peripheral with a commanded wait delay
`timescale 1ns/1ps
module ppe_periph_model (
  // bench controls and host pins
  input wire clk_sys_i,
  input wire [7:0] dly_i,
  input wire [7:0] byte_i,
  input wire [7:0] pd_i,
  input wire oe_n_i,
  input wire wr_n_i,
  input wire ds_n_i,
  input wire as_n_i,
  // peripheral pins
  output reg hold_n_o = 1'b0,
  output wire [7:0] bus_o,
  output reg [7:0] got_o
);
  reg [7:0] cnt_q = 8'h00;
  reg [7:0] last_q = 8'h00;
  wire stb = !ds_n_i || !as_n_i;
  // host wins; a released bus shows the inverse of its last level
  assign bus_o = !oe_n_i ? pd_i :
    stb && wr_n_i ? byte_i : ~last_q;
  // wait low between cycles, raised after the delay; writes captured
  always @(posedge clk_sys_i) begin
    last_q <= bus_o;
    if (!stb) {cnt_q, hold_n_o} <= 9'h000;
    else if (cnt_q >= dly_i) hold_n_o <= 1'b1;
    else cnt_q <= cnt_q + 8'h01;
    if (stb && !oe_n_i) got_o <= bus_o;
  end
endmodule

// ---- ppe_port_tb.sv ----
// random and corner-case bench for ppe_port
`timescale 1ns/1ps
`include "ppe_consts.vh"
module ppe_port_tb;
  reg clk_sys_i = 1'b0, nrst_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0;
  reg periph_irq_line_i = 1'b0;
  reg [3:0] io_sel_i = 4'h0;
  reg [4:0] periph_status_i = 5'h00;
  reg [2:0] cfg_irq_sel_i = 3'h0, cfg_dma_sel_i = 3'h0;
  reg [7:0] io_wdata_i = 8'h00, dly = 8'h00, rb = 8'h00, rd, v;
  reg [31:0] r;
  wire [7:0] io_rdata_o, port_data_bus_i, port_data_out_o, got;
  wire io_ready_o, port_data_oe_n_o, host_to_periph_flag_n_o, periph_irq_o;
  wire data_phase_strobe_n_o, addr_phase_strobe_n_o, periph_hold_n_i;
  wire periph_reset_n_o;
  wire [7:0] pins = {3'h0, host_to_periph_flag_n_o, periph_reset_n_o,
    data_phase_strobe_n_o, addr_phase_strobe_n_o, port_data_oe_n_o};
  integer seed = 32'hde01, err_count = 0, cmp_count = 0, i, n;
  reg [1:0] stb_seen = 2'b00;
  ppe_port dut_u (.*);
  ppe_periph_model cable_u (.clk_sys_i, .dly_i(dly), .byte_i(rb),
    .pd_i(port_data_out_o), .oe_n_i(port_data_oe_n_o),
    .wr_n_i(host_to_periph_flag_n_o), .ds_n_i(data_phase_strobe_n_o),
    .as_n_i(addr_phase_strobe_n_o), .hold_n_o(periph_hold_n_i),
    .bus_o(port_data_bus_i), .got_o(got));
  always #20 clk_sys_i = ~clk_sys_i;
  // strobes raised since the last request: bit1 address, bit0 data
  always @(posedge clk_sys_i) begin
    if (io_rd_i || io_wr_i)
      stb_seen <= 2'b00;
    else
      stb_seen <= stb_seen |
        {~addr_phase_strobe_n_o, ~data_phase_strobe_n_o};
  end
  // expected line_status image from status pins and timeout flag
  function [7:0] stat_exp(input [4:0] s, input t);
    stat_exp = {~s[4], s[3:0], 2'b00, t};
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // one host request; waits for the final sync and keeps the answer
  task io(input wr, input [3:0] sel, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      {io_wr_i, io_rd_i, io_sel_i, io_wdata_i} <= {wr, !wr, sel, d};
      @(posedge clk_sys_i);
      {io_wr_i, io_rd_i} <= 2'b00;
      n = 0;
      @(negedge clk_sys_i);
      while (io_ready_o !== 1'b1 && n < 300) begin
        @(negedge clk_sys_i);
        n = n + 1;
      end
      if (n == 300) chk(8'h00, 8'h01);
      rd = io_rdata_o;
    end
  endtask
  // new cable delay, read byte and slow inputs from the seeded stream
  task rnd;
    begin
      @(posedge clk_sys_i);
      r = $random(seed);
      {cfg_dma_sel_i, cfg_irq_sel_i, periph_status_i, periph_irq_line_i, rb}
        <= r[31:12];
      dly <= {4'h0, r[3:0]};
      v = r[11:4];
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    chk(pins, 8'h17);
    nrst_i <= 1'b1;
    io(1'b1, `PPE_SEL_DCR, 8'h04);
    io(1'b1, `PPE_SEL_ECR, 8'h80);
    chk(pins, 8'h0e);
    for (i = 0; i < 16; i = i + 1) begin
      if (i == 8) begin
        io(1'b0, `PPE_SEL_DATA, 8'h00);
        chk(rd, v);
        io(1'b1, `PPE_SEL_DCR, 8'h24);
        @(negedge clk_sys_i); // pins follow line_control a cycle later
        chk(pins, 8'h1f);
      end
      rnd;
      io(i < 8, i[0] ? `PPE_SEL_EPPA : `PPE_SEL_EPPD, v);
      chk(i < 8 ? got : rd, i < 8 ? v : rb);
      chk({6'h00, stb_seen}, i[0] ? 8'h02 : 8'h01);
    end
    dly <= 8'hff;
    io(1'b0, `PPE_SEL_EPPD, 8'h00);
    io(1'b0, `PPE_SEL_DSR, 8'h00);
    chk(rd, stat_exp(periph_status_i, 1'b1));
    io(1'b0, `PPE_SEL_DSR, 8'h00);
    chk(rd, stat_exp(periph_status_i, 1'b0));
    io(1'b0, `PPE_SEL_PORT_CONFIG_B, 8'h00);
    chk(rd, {1'b0, periph_irq_line_i, cfg_irq_sel_i, cfg_dma_sel_i});
    // pushes rotate over all four fifo ports, pops over the readable two
    for (i = 0; i < 16; i = i + 1)
      io(1'b1, `PPE_SEL_AFIFO + {2'b00, i[1:0]}, v + i[7:0]);
    io(1'b0, `PPE_SEL_ECR, 8'h00);
    chk(rd & 8'h03, 8'h02);
    for (i = 0; i < 16; i = i + 1) begin
      io(1'b0, i[0] ? `PPE_SEL_TEST_FIFO_PORT : `PPE_SEL_DFIFO, 8'h00);
      chk(rd, v + i[7:0]);
    end
    io(1'b0, `PPE_SEL_ECR, 8'h00);
    chk(rd & 8'h03, 8'h01);
    report_and_stop;
  end
  // cuts a hung run short
  initial begin
    #400000 err_count = err_count + 1;
    report_and_stop;
  end
endmodule
